/* File: rtl/tpg_pkg.sv */
// constants, register map and types of the three-phase pwm generator
// Summary of operation
// R1: prescaler divides clock by one to eight
// R2: new prescaler value applied at update event
// R3: center mode counts up then down
// R4: center: low on up match, high down
// R5: compare above carrier high, zero low
// R6: edge mode clears counter after carrier value
// R7: edge: low on up match, high on clear
// R8: compare counter extended to thirteen bits
// R9: low byte first, transfer waits high byte
// R10: eight-bit mode overflow bits, cleared on update
// R11: reads return preload, not active value
// R12: left-aligned thirteen bits, rounded when loading
// R13: software never writes carrier compare zero
// R14: transfer at turn when repetition count zero
// R15: center mode decrements repetition on both turns
// R16: repetition counter reloads itself at zero
// R17: update flag raised with each update event
// R18: writing all ones restarts counter, forces update
// R19: restart write touches only update flag
// R20: software reloads, restarts, then clears flag
// R21: disabled counter held zero; enabling forces update
// R22: runs in wait, frozen in halt
// R23: three phase compares plus carrier compare
package tpg_pkg;

  // register byte addresses, one word each
  localparam logic [7:0] TPG_CTRL_ADDR = 8'h00;
  localparam logic [7:0] TPG_REP_ADDR = 8'h04;
  localparam logic [7:0] TPG_ISR_ADDR = 8'h08;
  localparam logic [7:0] TPG_IMR_ADDR = 8'h0C;
  localparam logic [7:0] TPG_STAT_ADDR = 8'h10;
  // compare pairs: low byte at 0x20 + 8*i, high byte 4 above; i=0 carrier, 1..3 phases u, v, w
  localparam logic [2:0] TPG_CMP_REGION = 3'h1;

  // field positions
  localparam int unsigned TPG_UPD_BIT = 7;
  localparam int unsigned TPG_STAT_DIR_BIT = 12;
  localparam int unsigned TPG_STAT_REP_LSB = 16;

  localparam logic [7:0] TPG_RESYNC_CODE = 8'hFF;
  localparam logic [7:0] TPG_REP_RST = 8'h00;
  localparam logic [7:0] TPG_BYTE_RST = 8'h00;
  localparam logic [12:0] TPG_CMP13_MAX = 13'h1FFF;

  // control word, low nine bits of the control register
  typedef struct packed {
    logic clk_en;
    logic [2:0] phase_overflow_bit;
    logic eight_bit_select;
    logic center_align_select;
    logic [2:0] prescale_select;
  } tpg_ctrl_type;

  // buffered part of the control word
  typedef struct packed {
    logic eight_bit_select;
    logic center_align_select;
    logic [2:0] prescale_select;
  } tpg_cfg_type;

  localparam tpg_ctrl_type TPG_CTRL_RST = '0;
  localparam tpg_cfg_type TPG_CFG_RST = '0;

endpackage : tpg_pkg

/* File: rtl/tpg_pwm.sv */
// three-phase pwm generator with ahb-lite register slave
//
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tpg_pwm (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic halt_mode,
  output logic [2:0] pwm_out,
  output logic update_event,
  output logic pwm_update_irq
);
  import tpg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // declarations
  tpg_ctrl_type ctrl;
  tpg_cfg_type act_cfg;
  logic [7:0] repetition_reg;
  logic update_flag;
  logic update_interrupt_mask;
  logic [7:0] compare_low_byte [4];
  logic [7:0] compare_high_byte [4];
  logic [3:0] hi_pending;
  logic [12:0] act_cmp [4];
  logic [11:0] cnt;
  logic dir_down;
  logic [2:0] presc_cnt;
  logic [7:0] rep_cnt;
  logic en_q;
  logic dp_we;
  logic rd_pend;
  logic [7:0] dp_addr;
  logic acc;
  logic run;
  logic tick;
  logic per_evt;
  logic resync;
  logic en_rise;
  logic upd;
  logic cmp_wr;
  logic [1:0] cmp_idx;
  logic [3:0] ovf_ext;
  logic [11:0] carrier_compare;

  // rounds a left-aligned 16-bit value to 13 bits, saturating
  function automatic logic [12:0] round13(input logic [15:0] v);
    logic [13:0] s;
    s = {1'b0, v[15:3]} + {13'h0, v[2]};
    return s[13] ? TPG_CMP13_MAX : s[12:0];
  endfunction : round13

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: writes take no wait state, reads take one
  assign acc = hsel & hready & htrans[1];
  assign hreadyout = ~rd_pend;
  assign hresp = 1'b0;

  // address phase capture; upper address bits are not decoded
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_we <= 1'b0;
      dp_addr <= 8'h00;
    end else if (hready) begin
      dp_we <= acc & hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  // wait state lets a read see a write committed just before it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend <= 1'b0;
    end else begin
      rd_pend <= acc & ~hwrite & ~rd_pend;
    end
  end

  assign cmp_wr = dp_we & (dp_addr[7:5] == TPG_CMP_REGION) & ~halt_mode;
  assign cmp_idx = dp_addr[4:3];
  assign resync = dp_we & ~halt_mode & (dp_addr == TPG_ISR_ADDR) & (hwdata[7:0] == TPG_RESYNC_CODE);

  // read data; compare reads show preload bytes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (rd_pend) begin
      hrdata <= 32'h0;
      if (dp_addr[7:5] == TPG_CMP_REGION) begin
        hrdata[7:0] <= dp_addr[2] ? compare_high_byte[cmp_idx] : compare_low_byte[cmp_idx]; // [R11]
      end else begin
        unique case (dp_addr)
          TPG_CTRL_ADDR: hrdata[8:0] <= ctrl;
          TPG_REP_ADDR: hrdata[7:0] <= repetition_reg;
          TPG_ISR_ADDR: hrdata[TPG_UPD_BIT] <= update_flag;
          TPG_IMR_ADDR: hrdata[TPG_UPD_BIT] <= update_interrupt_mask;
          TPG_STAT_ADDR: begin
            hrdata[11:0] <= cnt;
            hrdata[TPG_STAT_DIR_BIT] <= dir_down;
            hrdata[TPG_STAT_REP_LSB +: 8] <= rep_cnt;
          end
          default: hrdata <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers; halt freezes them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= TPG_CTRL_RST;
      repetition_reg <= TPG_REP_RST;
      update_interrupt_mask <= 1'b0;
    end else if (!halt_mode) begin
      if (dp_we && dp_addr == TPG_CTRL_ADDR) begin
        ctrl <= tpg_ctrl_type'(hwdata[8:0]);
      end else if (upd) begin
        ctrl.phase_overflow_bit <= 3'h0; // [R10]
      end
      if (dp_we && dp_addr == TPG_REP_ADDR) begin
        repetition_reg <= hwdata[7:0];
      end
      if (dp_we && dp_addr == TPG_IMR_ADDR) begin
        update_interrupt_mask <= hwdata[TPG_UPD_BIT];
      end
    end
  end

  // update flag: set wins over a clearing write; only this flag lives here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      update_flag <= 1'b0;
    end else if (!halt_mode) begin
      if (upd) begin
        update_flag <= 1'b1; // [R17] [R19]
      end else if (dp_we && dp_addr == TPG_ISR_ADDR && !hwdata[TPG_UPD_BIT]) begin
        update_flag <= 1'b0; // [R20]
      end
    end
  end

  assign pwm_update_irq = update_flag & update_interrupt_mask; // [R19]

  ////////////////////////////////////////////////////////////////////////
  // prescaler and event decode
  assign run = ctrl.clk_en & ~halt_mode; // [R22]
  assign en_rise = ctrl.clk_en & ~en_q & ~halt_mode;
  assign tick = run & (presc_cnt >= act_cfg.prescale_select); // [R1]
  assign carrier_compare = act_cmp[0][11:0];
  assign per_evt = tick & (dir_down ? (cnt == 12'h000) : (cnt >= carrier_compare)); // [R15]
  assign upd = (per_evt & (rep_cnt == 8'h00)) | resync | en_rise; // [R14] [R18] [R21]

  // divide by prescale_select + 1
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_cnt <= 3'h0;
      en_q <= 1'b0;
    end else if (!halt_mode) begin
      en_q <= ctrl.clk_en;
      if (!ctrl.clk_en || resync || tick) begin
        presc_cnt <= 3'h0; // [R1]
      end else begin
        presc_cnt <= presc_cnt + 3'h1;
      end
    end
  end

  // buffered mode and prescaler, taken only at update
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_cfg <= TPG_CFG_RST;
    end else if (upd) begin
      act_cfg <= {ctrl.eight_bit_select, ctrl.center_align_select, ctrl.prescale_select}; // [R2]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // 12-bit up/down counter; a zero carrier would stall it in edge mode and wrap it to 0xFFF in center mode, software avoids it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 12'h000;
      dir_down <= 1'b0;
    end else if (!halt_mode) begin
      if (!ctrl.clk_en || resync) begin
        cnt <= 12'h000; // [R21] [R18]
        dir_down <= 1'b0;
      end else if (tick) begin
        if (!act_cfg.center_align_select) begin
          dir_down <= 1'b0;
          cnt <= (cnt >= carrier_compare) ? 12'h000 : cnt + 12'h001; // [R6]
        end else if (!dir_down) begin
          if (cnt >= carrier_compare) begin
            dir_down <= 1'b1; // [R3] [R13]
            cnt <= cnt - 12'h001;
          end else begin
            cnt <= cnt + 12'h001;
          end
        end else if (cnt == 12'h000) begin
          dir_down <= 1'b0; // [R3]
          cnt <= 12'h001;
        end else begin
          cnt <= cnt - 12'h001;
        end
      end
    end
  end

  // repetition down-counter, reloads itself at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rep_cnt <= TPG_REP_RST;
    end else if (!halt_mode) begin
      if (!ctrl.clk_en || resync || en_rise) begin
        rep_cnt <= repetition_reg;
      end else if (per_evt) begin
        rep_cnt <= (rep_cnt == 8'h00) ? repetition_reg : rep_cnt - 8'h01; // [R15] [R16]
      end
    end
  end

  // debug copy of the update event
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      update_event <= 1'b0;
    end else begin
      update_event <= upd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // compare preloads and active registers: 0 carrier, 1..3 phases
  assign ovf_ext = {ctrl.phase_overflow_bit, 1'b0};

  for (genvar i = 0; i < 4; i++) begin : g_cmp
    logic lo_hit;
    logic hi_hit;
    logic [12:0] rnd;
    assign lo_hit = cmp_wr & (cmp_idx == 2'(i)) & ~dp_addr[2];
    assign hi_hit = cmp_wr & (cmp_idx == 2'(i)) & dp_addr[2];
    assign rnd = round13({compare_high_byte[i], compare_low_byte[i]}); // [R12]

    // preload bytes and the high-byte wait
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        compare_low_byte[i] <= TPG_BYTE_RST;
        compare_high_byte[i] <= TPG_BYTE_RST;
        hi_pending[i] <= 1'b0;
      end else begin
        if (lo_hit) begin
          compare_low_byte[i] <= hwdata[7:0];
        end
        if (hi_hit) begin
          compare_high_byte[i] <= hwdata[7:0];
        end
        if (hi_hit || ctrl.eight_bit_select) begin
          hi_pending[i] <= 1'b0; // [R9]
        end else if (lo_hit) begin
          hi_pending[i] <= 1'b1; // [R9]
        end
      end
    end

    // a half-written pair stays out until its high byte lands or eight-bit mode is selected
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        act_cmp[i] <= 13'h0000;
      end else if (upd && !hi_pending[i]) begin // [R9] [R14]
        if (ctrl.eight_bit_select) begin
          act_cmp[i] <= {4'h0, ovf_ext[i], compare_low_byte[i]}; // [R10]
        end else if (i == 0) begin
          act_cmp[i] <= {1'b0, rnd[11:0]}; // [R12]
        end else begin
          act_cmp[i] <= rnd; // [R12] [R23]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // phase outputs from the extended 13-bit comparison
  for (genvar j = 0; j < 3; j++) begin : g_phase
    logic [12:0] cnt13;
    logic [12:0] cmp;
    assign cnt13 = {1'b0, cnt}; // [R8]
    assign cmp = act_cmp[j + 1];

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        pwm_out[j] <= 1'b0;
      end else if (!halt_mode) begin
        if (cmp == 13'h0000) begin
          pwm_out[j] <= 1'b0; // [R5]
        end else if (cmp > {1'b0, carrier_compare}) begin
          pwm_out[j] <= 1'b1; // [R5]
        end else if (act_cfg.center_align_select && dir_down) begin
          pwm_out[j] <= (cnt13 <= cmp); // [R4]
        end else begin
          pwm_out[j] <= (cnt13 < cmp); // [R4] [R7]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_presc_two;
    @(posedge hclk) disable iff (!hresetn)
      (tick && run && act_cfg.prescale_select == 3'h1 && !upd && !resync ##1 run && !upd)
      |-> !tick ##1 tick;
  endproperty
  a_presc_two: assert property (p_presc_two) else $error("prescaler by two wrong"); // [R1]

  property p_hold_zero;
    @(posedge hclk) disable iff (!hresetn)
      (!ctrl.clk_en && !halt_mode) |=> (cnt == 12'h000 && !dir_down);
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("disabled counter not zero"); // [R21]

  property p_enable_update;
    @(posedge hclk) disable iff (!hresetn)
      en_rise |=> (update_flag && update_event);
  endproperty
  a_enable_update: assert property (p_enable_update) else $error("enable gave no update"); // [R21]

  property p_resync;
    @(posedge hclk) disable iff (!hresetn)
      resync |=> (cnt == 12'h000 && update_flag && act_cfg.prescale_select == $past(ctrl.prescale_select));
  endproperty
  a_resync: assert property (p_resync) else $error("resync did not restart"); // [R18]

  property p_edge_wrap;
    @(posedge hclk) disable iff (!hresetn)
      (tick && !act_cfg.center_align_select && cnt >= carrier_compare && !resync && !halt_mode)
      |=> cnt == 12'h000;
  endproperty
  a_edge_wrap: assert property (p_edge_wrap) else $error("edge counter did not clear"); // [R6]

  property p_center_turn;
    @(posedge hclk) disable iff (!hresetn)
      (tick && act_cfg.center_align_select && !dir_down && cnt >= carrier_compare && !resync)
      |=> dir_down && cnt == $past(cnt) - 12'h001;
  endproperty
  a_center_turn: assert property (p_center_turn) else $error("center turn wrong"); // [R3]

  property p_zero_low;
    @(posedge hclk) disable iff (!hresetn)
      (act_cmp[1] == 13'h0000 && !halt_mode) |=> !pwm_out[0];
  endproperty
  a_zero_low: assert property (p_zero_low) else $error("zero compare not low"); // [R5]

  property p_ovf_clear;
    @(posedge hclk) disable iff (!hresetn)
      (upd && !(dp_we && dp_addr == TPG_CTRL_ADDR)) |=> ctrl.phase_overflow_bit == 3'h0;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow bits kept"); // [R10]

  property p_rep_reload;
    @(posedge hclk) disable iff (!hresetn)
      (per_evt && rep_cnt == 8'h00 && !halt_mode) |=> (rep_cnt == $past(repetition_reg) && update_flag);
  endproperty
  a_rep_reload: assert property (p_rep_reload) else $error("repetition not reloaded"); // [R16]

  property p_defer;
    @(posedge hclk) disable iff (!hresetn)
      (upd && hi_pending[1]) |=> act_cmp[1] == $past(act_cmp[1]);
  endproperty
  a_defer: assert property (p_defer) else $error("half pair transferred"); // [R9]

endmodule : tpg_pwm
`default_nettype wire

/* File: verification/tpg_chan_model.sv */
// far-side model of the channel manager: duty, edge and update counters over a window
`timescale 1ns/1ps
`default_nettype none
module tpg_chan_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [2:0] pwm_out,
  input wire logic update_event,
  input wire logic start,
  input wire logic [15:0] win_len,
  output logic done,
  output logic [4:0][31:0] cnt
);
  logic [15:0] left;
  logic prev_u;

  ////////////////////////////////////////////////////////////////////////////////
  // counts run only inside the window; a window of whole periods sees one rise per period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      left <= '0;
      cnt <= '0;
      done <= 1'b0;
      prev_u <= 1'b0;
    end else begin
      prev_u <= pwm_out[0];
      done <= (left == 16'h0001);
      if (start) begin
        left <= win_len;
        cnt <= '0;
      end else if (left != 16'h0000) begin
        left <= left - 16'h0001;
        for (int i = 0; i < 3; i++) begin
          cnt[i] <= cnt[i] + 32'(pwm_out[i]);
        end
        cnt[3] <= cnt[3] + 32'(pwm_out[0] & ~prev_u); // rises of phase u
        cnt[4] <= cnt[4] + 32'(update_event);
      end
    end
  end
endmodule : tpg_chan_model
`default_nettype wire

/* File: verification/tpg_pwm_tb_top.sv */
// self-checking bench for the three-phase pwm generator
`timescale 1ns/1ps
`default_nettype none
module tpg_pwm_tb_top;
  import tpg_pkg::*;
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR at %0t: got %h expected %h", $time, g, e); end end
  localparam logic [31:0] SKIP = 32'hFFFF_FFFF;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic halt_mode = 1'b0;
  logic hreadyout, hresp, pwm_update_irq, update_event, m_done;
  logic [31:0] hrdata;
  logic [2:0] pwm_out;
  logic [4:0][31:0] m_cnt;
  logic m_start = 1'b0;
  logic [15:0] m_len = '0;
  logic rd_dp = 1'b0;
  logic probe_stb = 1'b0;
  logic [31:0] probe_val = '0;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'hFA4A;
  logic [31:0] v;
  int err_count = 0;
  int checked = 0;

  always #5 hclk = ~hclk;

  // hready follows the single slave; hsize fixed to a word
  tpg_pwm dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .halt_mode(halt_mode), .pwm_out(pwm_out),
    .update_event(update_event), .pwm_update_irq(pwm_update_irq));
  tpg_chan_model far_end (.hclk(hclk), .hresetn(hresetn), .pwm_out(pwm_out),
    .update_event(update_event), .start(m_start), .win_len(m_len), .done(m_done), .cnt(m_cnt));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic cmp(input logic [31:0] g);
    logic [31:0] e;
    e = exp_q.pop_front();
    if (e !== SKIP) `CHK(g, e)
  endtask : cmp

  // oldest note is compared with whichever result shows at this edge
  always @(posedge hclk) begin
    if (rd_dp && hreadyout) cmp(hrdata);
    if (probe_stb) cmp(probe_val);
    if (m_done) for (int i = 0; i < 5; i++) cmp(m_cnt[i]);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // address phase held until hready is seen high
  task automatic addr_ph(input logic [7:0] a, input logic w);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (!hreadyout);
    htrans <= 2'h0;
    hsel <= 1'b0;
  endtask : addr_ph

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_ph(a, 1'b1);
    hwdata <= d;
    do @(posedge hclk); while (!hreadyout);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    addr_ph(a, 1'b0);
    rd_dp <= 1'b1;
    do @(posedge hclk); while (!hreadyout);
    rd_dp <= 1'b0;
  endtask : rd

  // the flag is set one edge after the event that causes it, so wait two edges before sampling
  task automatic probe(input logic [31:0] e);
    repeat (2) @(posedge hclk);
    exp_q.push_back(e);
    probe_val <= 32'(pwm_update_irq);
    probe_stb <= 1'b1;
    @(posedge hclk);
    probe_stb <= 1'b0;
    @(posedge hclk);
  endtask : probe

  // expected: high cycles of u, v, w, rises of u, update pulses
  task automatic measure(input logic [15:0] len, input logic [31:0] u, w2, w3, r, n);
    exp_q = {exp_q, u, w2, w3, r, n};
    m_len <= len;
    m_start <= 1'b1;
    @(posedge hclk);
    m_start <= 1'b0;
    do @(posedge hclk); while (!m_done);
  endtask : measure

  task automatic wrap_up;
    if (exp_q.size() != 0) err_count++;
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, then an unmapped hole that ignores writes
    for (int a = 0; a <= 20; a += 4) rd(8'(a), 32'h0);
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14, 32'h0);
    wr(8'h28, 32'h16);
    rd(8'h28, 32'h16);
    // twelve-bit pairs, low byte first; carrier never zero
    wr(8'h20, 32'h48);
    wr(8'h24, 32'h0);
    wr(8'h2C, 32'h0);
    wr(8'h38, 32'h50);
    wr(8'h3C, 32'h0);
    wr(8'h0C, 32'h80);
    // a long repetition keeps periodic updates away from the flag checks
    wr(8'h04, 32'hFF);
    wr(8'h00, 32'h100);
    probe(32'h1);
    rd(8'h08, 32'h80);
    wr(8'h08, 32'h7F);
    rd(8'h08, 32'h0);
    // back to an update every period; restart reloads the repetition count
    wr(8'h04, 32'h0);
    wr(8'h08, 32'hFF);
    repeat (40) @(posedge hclk);
    measure(100, 32'h1E, 32'h0, 32'h64, 32'hA, 32'hA);
    // low byte alone must not reach the active compare
    wr(8'h28, 32'h30);
    repeat (30) @(posedge hclk);
    measure(100, 32'h1E, 32'h0, 32'h64, 32'hA, 32'hA);
    wr(8'h2C, 32'h0);
    repeat (30) @(posedge hclk);
    measure(100, 32'h3C, 32'h0, 32'h64, 32'hA, 32'hA);
    // eight-bit mode with random duty
    // low bytes first: in twelve-bit mode they wait, so the carrier never passes through 1
    wr(8'h20, 32'h9);
    wr(8'h38, 32'hA);
    wr(8'h00, 32'h110);
    repeat (30) @(posedge hclk);
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      v = 32'h1 + seed % 32'h9;
      wr(8'h28, v);
      repeat (30) @(posedge hclk);
      measure(100, 32'hA * v, 32'h0, 32'h64, 32'hA, 32'hA);
    end
    wr(8'h28, 32'h3);
    wr(8'h00, 32'h130);
    repeat (30) @(posedge hclk);
    rd(8'h00, 32'h110);
    // prescaler halves the count rate after an update
    wr(8'h00, 32'h111);
    repeat (60) @(posedge hclk);
    measure(200, 32'h3C, 32'h0, 32'hC8, 32'hA, 32'hA);
    // center-aligned: two turns per period
    wr(8'h00, 32'h118);
    repeat (60) @(posedge hclk);
    measure(180, 32'h3C, 32'h0, 32'hB4, 32'hA, 32'h14);
    wr(8'h04, 32'h1);
    repeat (60) @(posedge hclk);
    measure(180, 32'h3C, 32'h0, 32'hB4, 32'hA, 32'hA);
    // long repetition: new preload waits
    wr(8'h04, 32'hFF);
    repeat (60) @(posedge hclk);
    wr(8'h28, 32'h6);
    repeat (30) @(posedge hclk);
    measure(180, 32'h3C, 32'h0, 32'hB4, 32'hA, 32'h0);
    // restart write forces the transfer and the flag
    wr(8'h08, 32'hFF);
    repeat (20) @(posedge hclk);
    probe(32'h1);
    measure(180, 32'h78, 32'h0, 32'hB4, 32'hA, 32'h0);
    wr(8'h0C, 32'h0);
    probe(32'h0);
    wr(8'h0C, 32'h80);
    wr(8'h08, 32'h7F);
    probe(32'h0);
    // halt freezes counter and outputs
    halt_mode <= 1'b1;
    repeat (5) @(posedge hclk);
    measure(100, SKIP, 32'h0, 32'h64, 32'h0, 32'h0);
    halt_mode <= 1'b0;
    // let the monitor take the last window's counts before closing
    repeat (2) @(posedge hclk);
    wrap_up();
  end
endmodule : tpg_pwm_tb_top
`default_nettype wire
